// File: rtl/bps_pkg.sv
// package: shared constants and state codes of the blanking packet sender
// assumes: one transcoder clock, registers reached as plain ports
package bps_pkg;

    // ------------------------------------------------------------
    // metadata buffer geometry
    // ------------------------------------------------------------
    localparam int META_WORDS = 256;
    localparam int META_PKT_PAYLOAD = 8;
    localparam int MAX_PKT_PAYLOAD_ONLY = 32;
    localparam int MAX_PKT_WITH_HEADER = 28;

    // ------------------------------------------------------------
    // register field positions
    // ------------------------------------------------------------
    localparam int CTL_INDEX_MSB = 7;
    localparam int CTL_AUTOINC_BIT = 14;
    localparam int CTL_READY_BIT = 16;
    localparam int CTL_EMPTY_BIT = 24;
    localparam int CONF_LEN_MSB = 9;
    localparam int CONF_DONE_BIT = 31;
    localparam int MISC_BLOCK_BIT = 22;

    // ------------------------------------------------------------
    // island packet storage
    // ------------------------------------------------------------
    localparam int ISL_PAYLOAD = 8;
    localparam int PPS_PAYLOAD = 32;
    localparam logic [5:0] ISL_LAST_IDX = 6'h20;
    localparam logic [5:0] ISL_ECC_IDX = 6'h21;
    localparam logic [31:0] NULL_HEADER = 32'h0000_0000;

    // ------------------------------------------------------------
    // reset values and output fifo depth
    // ------------------------------------------------------------
    localparam logic [1:0] EMPTY_RESET = 2'h3;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [5:0] {
        ST_IDLE      = 6'h01,
        ST_ISL_RD    = 6'h02,
        ST_ISL_PUSH  = 6'h04,
        ST_NULL      = 6'h08,
        ST_META_RD   = 6'h10,
        ST_META_PUSH = 6'h20
    } bps_state_t;

endpackage

// File: rtl/bps_fifo.sv
// fifo between the packet sequencer and the link formatter
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module bps_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("bps_fifo: depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } bps_fifo_regs_t;

    bps_fifo_regs_t p_q;
    bps_fifo_regs_t p_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    // ------------------------------------------------------------
    // flags and pointers
    // ------------------------------------------------------------
    assign inReady = (p_q.wr[AW-1:0] != p_q.rd[AW-1:0]) || (p_q.wr[AW] == p_q.rd[AW]);
    assign outValid = p_q.wr != p_q.rd;
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;
    assign outData = mem[p_q.rd[AW-1:0]];

    always_comb begin
        p_d = p_q;
        if (doPush) begin
            p_d.wr = p_q.wr + 1'b1;
        end
        if (doPop) begin
            p_d.rd = p_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            p_q <= '0;
        end else begin
            p_q <= p_d;
        end
    end

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[p_q.wr[AW-1:0]] <= inData;
        end
    end

endmodule // bps_fifo
`default_nettype wire

// File: rtl/bps_sender.sv
// blanking packet sender: island packets and ping-pong extension metadata
// assumes: timing strobes from the transcoder, registers as plain ports
//
// Notes on behaviour
// - stored packet words and their ecc bytes can be read back anytime
// - clearing an enable mid-packet still lets that packet finish
// - port disable aborts transfer at once; enables stay as they are
// - enable raised at the slot itself waits for the next frame
// - on hdmi with nothing enabled one null packet goes out
// - packet words go out exactly as stored, never interpreted
// - one packet type carries a 128-byte picture parameter payload
// - metadata path holds up to 1K bytes per buffer
// - with audio on, metadata only in horizontal active of vblank
// - metadata flows in vblank while a ready buffer is not empty
// - index set by software or auto-incremented; reads start at 0; wraps
// - buffer holds 32 payload-only packets or 28 with headers
// - control word: auto-increment bit 14, ready 16, empty 24
// - chain config: packet count bits 9..0, chain done bit 31
// - block mode at misc bit 22 takes headers from the buffer
// - each enabled packet type goes out once per frame
`timescale 1ns/1ns
`default_nettype none
module bps_sender import bps_pkg::*; #(
    parameter int NTYPE = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic portEnable,
    input wire logic hdmiMode,
    input wire logic audioEnable,
    input wire logic vblank,
    input wire logic hActive,
    input wire logic packetSlot,
    input wire logic [NTYPE-1:0] islandEnable,
    input wire logic islandWe,
    input wire logic [$clog2(NTYPE)-1:0] islandType,
    input wire logic [5:0] islandIdx,
    input wire logic [31:0] islandWdata,
    input wire logic [$clog2(NTYPE)-1:0] rdType,
    input wire logic [5:0] rdIdx,
    output logic [31:0] rdData,
    input wire logic [1:0] metaCtlWe,
    input wire logic [31:0] metaCtlWdata,
    input wire logic [1:0] metaDataWe,
    input wire logic [31:0] metaDataWdata,
    input wire logic metaConfWe,
    input wire logic [31:0] metaConfWdata,
    input wire logic metaHeaderWe,
    input wire logic [31:0] metaHeaderWdata,
    input wire logic metaMiscWe,
    input wire logic [31:0] metaMiscWdata,
    output logic [31:0] metaBuf0Control,
    output logic [31:0] metaBuf1Control,
    output logic [31:0] metaChainConfig,
    output logic outValid,
    input wire logic outReady,
    output logic [31:0] outData,
    output logic outFirst,
    output logic outLast
);
    localparam int TW = $clog2(NTYPE);
    localparam logic [TW-1:0] PPS_TYPE = TW'(NTYPE - 1);

    if (NTYPE < 2 || (1 << TW) != NTYPE) begin : g_bad
        $error("bps_sender: NTYPE must be a power of two, at least 2");
    end

    typedef struct packed {
        bps_state_t st;
        logic [NTYPE-1:0] enPrev;
        logic [NTYPE-1:0] pending;
        logic [TW-1:0] typeIdx;
        logic [5:0] wordIdx;
        logic [3:0] pktWord;
        logic curBuf;
        logic [1:0][8:0] rdPtr;
        logic [1:0][8:0] fill;
        logic [1:0][7:0] index;
        logic [1:0] autoInc;
        logic [1:0] ready;
        logic [1:0] empty;
        logic [9:0] chainLen;
        logic [9:0] chainCnt;
        logic chainDone;
        logic blockMode;
        logic [31:0] header;
        logic [NTYPE-1:0][7:0] ecc;
    } bps_regs_t;

    bps_regs_t s_q;
    bps_regs_t s_d;
    logic [31:0] islMem [NTYPE][33];
    logic [31:0] metaMem [2][META_WORDS];
    logic [31:0] islRd_q;
    logic [31:0] metaRd_q;
    logic [31:0] rdData_q;
    logic pushValid;
    logic pushFirst;
    logic pushLast;
    logic [31:0] pushData;
    logic fifoInReady;
    logic [33:0] fifoOut;
    logic [1:0] avail;
    logic metaGo;
    logic metaSel;
    logic hdrFromReg;
    logic [1:0] emptySet;
    logic [NTYPE-1:0] pend;
    logic [8:0] rdNext;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [TW-1:0] firstSet(input logic [NTYPE-1:0] v);
        logic [TW-1:0] r;
        r = '0;
        for (int i = NTYPE - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = TW'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [5:0] lenOf(input logic [TW-1:0] t);
        return (t == PPS_TYPE) ? 6'(PPS_PAYLOAD) : 6'(ISL_PAYLOAD);
    endfunction

    function automatic logic [7:0] byteXor(input logic [31:0] w);
        return w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24];
    endfunction

    function automatic logic [31:0] ctlWord(input logic [7:0] idx, input logic inc,
                                            input logic rdy, input logic emp);
        logic [31:0] w;
        w = '0;
        w[CTL_INDEX_MSB:0] = idx;
        w[CTL_AUTOINC_BIT] = inc;
        w[CTL_READY_BIT] = rdy;
        w[CTL_EMPTY_BIT] = emp;
        return w;
    endfunction

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    always_comb begin
        metaBuf0Control = ctlWord(s_q.index[0], s_q.autoInc[0], s_q.ready[0], s_q.empty[0]);
        metaBuf1Control = ctlWord(s_q.index[1], s_q.autoInc[1], s_q.ready[1], s_q.empty[1]);
        metaChainConfig = '0;
        metaChainConfig[CONF_LEN_MSB:0] = s_q.chainLen;
        metaChainConfig[CONF_DONE_BIT] = s_q.chainDone;
    end

    assign avail = s_q.ready & ~s_q.empty;
    assign metaGo = vblank && (!audioEnable || hActive) && (|avail);
    assign metaSel = avail[s_q.curBuf] ? s_q.curBuf : ~s_q.curBuf;
    assign hdrFromReg = !s_q.blockMode && (s_q.pktWord == 4'h0);
    assign pend = s_q.enPrev & islandEnable;
    assign rdNext = s_q.rdPtr[s_q.curBuf] + 9'h001;

    // ------------------------------------------------------------
    // sequencer and register updates
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        pushValid = 1'b0;
        pushFirst = 1'b0;
        pushLast = 1'b0;
        pushData = '0;
        emptySet = '0;
        s_d.enPrev = islandEnable;
        unique case (s_q.st)
            ST_IDLE: begin
                if (portEnable && packetSlot) begin
                    s_d.pending = pend;
                    s_d.wordIdx = '0;
                    if (|pend) begin
                        s_d.typeIdx = firstSet(pend);
                        s_d.st = ST_ISL_RD;
                    end else if (hdmiMode) begin
                        s_d.st = ST_NULL;
                    end
                end else if (portEnable && metaGo) begin
                    s_d.curBuf = metaSel;
                    s_d.pktWord = '0;
                    s_d.st = ST_META_RD;
                end
            end
            ST_ISL_RD: begin
                s_d.st = ST_ISL_PUSH;
            end
            ST_ISL_PUSH: begin
                pushValid = 1'b1;
                pushData = islRd_q;
                pushFirst = s_q.wordIdx == 6'h00;
                pushLast = s_q.wordIdx == lenOf(s_q.typeIdx);
                if (fifoInReady) begin
                    s_d.wordIdx = s_q.wordIdx + 6'h01;
                    s_d.st = ST_ISL_RD;
                    if (pushLast) begin
                        s_d.pending[s_q.typeIdx] = 1'b0;
                        s_d.wordIdx = '0;
                        s_d.typeIdx = firstSet(s_d.pending);
                        s_d.st = (|s_d.pending) ? ST_ISL_RD : ST_IDLE;
                    end
                end
            end
            ST_NULL: begin
                pushValid = 1'b1;
                pushData = (s_q.wordIdx == 6'h00) ? NULL_HEADER : 32'h0000_0000;
                pushFirst = s_q.wordIdx == 6'h00;
                pushLast = s_q.wordIdx == 6'(ISL_PAYLOAD);
                if (fifoInReady) begin
                    s_d.wordIdx = s_q.wordIdx + 6'h01;
                    s_d.st = pushLast ? ST_IDLE : ST_NULL;
                end
            end
            ST_META_RD: begin
                s_d.st = ST_META_PUSH;
            end
            ST_META_PUSH: begin
                pushValid = 1'b1;
                pushData = hdrFromReg ? s_q.header : metaRd_q;
                pushFirst = s_q.pktWord == 4'h0;
                pushLast = s_q.pktWord == 4'(META_PKT_PAYLOAD);
                if (fifoInReady) begin
                    s_d.pktWord = s_q.pktWord + 4'h1;
                    s_d.st = ST_META_RD;
                    if (!hdrFromReg) begin
                        s_d.rdPtr[s_q.curBuf] = rdNext;
                    end
                    if (pushLast) begin
                        s_d.st = ST_IDLE;
                        s_d.chainCnt = s_q.chainCnt + 10'h001;
                        if (!s_q.blockMode && s_d.chainCnt == s_q.chainLen) begin
                            s_d.chainDone = 1'b1;
                            s_d.chainCnt = '0;
                        end
                        if (rdNext >= s_q.fill[s_q.curBuf]) begin
                            emptySet[s_q.curBuf] = 1'b1;
                            s_d.empty[s_q.curBuf] = 1'b1;
                            s_d.ready[s_q.curBuf] = 1'b0;
                            s_d.rdPtr[s_q.curBuf] = '0;
                            s_d.fill[s_q.curBuf] = '0;
                            s_d.curBuf = ~s_q.curBuf;
                            if (s_q.blockMode && s_q.empty[~s_q.curBuf]) begin
                                s_d.chainDone = 1'b1;
                            end
                        end
                    end
                end
            end
        endcase
        if (!portEnable) begin
            s_d.st = ST_IDLE;
            s_d.pending = '0;
        end
        if (metaConfWe) begin
            s_d.chainLen = metaConfWdata[CONF_LEN_MSB:0];
            s_d.chainCnt = '0;
            s_d.chainDone = s_d.chainDone && (s_d.chainDone != s_q.chainDone);
        end
        if (metaHeaderWe) begin
            s_d.header = metaHeaderWdata;
        end
        if (metaMiscWe) begin
            s_d.blockMode = metaMiscWdata[MISC_BLOCK_BIT];
        end
        for (int b = 0; b < 2; b++) begin
            if (metaCtlWe[b]) begin
                s_d.index[b] = metaCtlWdata[CTL_INDEX_MSB:0];
                s_d.autoInc[b] = metaCtlWdata[CTL_AUTOINC_BIT];
                s_d.ready[b] = metaCtlWdata[CTL_READY_BIT];
            end
            if (metaDataWe[b]) begin
                s_d.fill[b] = {1'b0, s_q.index[b]} + 9'h001;
                s_d.index[b] = s_q.index[b] + {7'h00, s_q.autoInc[b]};
                s_d.empty[b] = emptySet[b];
            end
        end
        if (islandWe && islandIdx <= ISL_LAST_IDX) begin
            s_d.ecc[islandType] = s_q.ecc[islandType]
                ^ byteXor(islMem[islandType][islandIdx]) ^ byteXor(islandWdata);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.empty <= EMPTY_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // packet storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int t = 0; t < NTYPE; t++) begin
                for (int w = 0; w <= int'(ISL_LAST_IDX); w++) begin
                    islMem[t][w] <= '0;
                end
            end
        end else if (islandWe && islandIdx <= ISL_LAST_IDX) begin
            islMem[islandType][islandIdx] <= islandWdata;
        end
        for (int b = 0; b < 2; b++) begin
            if (metaDataWe[b]) begin
                metaMem[b][s_q.index[b]] <= metaDataWdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            islRd_q <= '0;
            metaRd_q <= '0;
            rdData_q <= '0;
        end else begin
            islRd_q <= islMem[s_q.typeIdx][s_q.wordIdx];
            metaRd_q <= metaMem[s_q.curBuf][s_q.rdPtr[s_q.curBuf][7:0]];
            if (rdIdx == ISL_ECC_IDX) begin
                rdData_q <= {24'h000000, s_q.ecc[rdType]};
            end else if (rdIdx <= ISL_LAST_IDX) begin
                rdData_q <= islMem[rdType][rdIdx];
            end else begin
                rdData_q <= '0;
            end
        end
    end

    assign rdData = rdData_q;

    // ------------------------------------------------------------
    // output fifo
    // ------------------------------------------------------------
    bps_fifo #(.WIDTH(34), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData({pushFirst, pushLast, pushData}),
        .outValid(outValid),
        .outReady(outReady),
        .outData(fifoOut)
    );

    assign outFirst = fifoOut[33];
    assign outLast = fifoOut[32];
    assign outData = fifoOut[31:0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_slot_enable_late: assert property (s_q.st == ST_IDLE && portEnable && packetSlot
        && islandEnable[1] && !s_q.enPrev[1] |=> !s_q.pending[1])
        else $error("packet enabled at its slot was sent in the same frame");
    a_null_packet_go: assert property (s_q.st == ST_IDLE && portEnable && packetSlot
        && hdmiMode && pend == '0 |=> s_q.st == ST_NULL ##9 s_q.st != ST_NULL)
        else $error("null packet missing on hdmi");
    a_port_off_abort: assert property (!portEnable |=> s_q.st == ST_IDLE)
        else $error("transfer kept running with port disabled");
    a_packet_not_cut: assert property (s_q.st == ST_ISL_PUSH && fifoInReady && !pushLast
        && portEnable |=> s_q.st == ST_ISL_RD)
        else $error("island packet cut short");
    a_island_pending: assert property (s_q.st == ST_ISL_PUSH |-> s_q.pending[s_q.typeIdx])
        else $error("island packet sent without a pending frame slot");
    a_meta_window: assert property (s_q.st == ST_IDLE ##1 s_q.st == ST_META_RD
        |-> $past(vblank && (!audioEnable || hActive)))
        else $error("metadata started outside its blanking window");
    a_meta_flows: assert property (s_q.st == ST_IDLE && portEnable && !packetSlot
        && metaGo |=> s_q.st == ST_META_RD ##1 s_q.st == ST_META_PUSH)
        else $error("ready metadata buffer not drained");
    a_drain_clears: assert property ($rose(s_q.empty[0]) && !$past(metaCtlWe[0])
        |-> !s_q.ready[0] && s_q.rdPtr[0] == 9'h000)
        else $error("drained buffer kept its ready bit");
    a_index_wraps: assert property (metaDataWe[0] && !metaCtlWe[0] && s_q.autoInc[0]
        && s_q.index[0] == 8'hFF |=> s_q.index[0] == 8'h00)
        else $error("buffer index failed to wrap");
    a_ecc_readback: assert property (rdIdx == ISL_ECC_IDX |=> rdData[31:8] == 24'h000000)
        else $error("ecc readback carries stray bits");
    a_chain_done_src: assert property ($rose(s_q.chainDone) |-> $past(s_q.st == ST_META_PUSH))
        else $error("chain done raised outside a metadata packet");

    c_island_sent: cover property (s_q.st == ST_ISL_PUSH && pushLast && fifoInReady);
    c_null_sent: cover property (s_q.st == ST_NULL && pushLast && fifoInReady);
    c_meta_sent: cover property (s_q.st == ST_META_PUSH && pushLast && fifoInReady);
    c_buffer_drained: cover property ($rose(s_q.empty[1]));

endmodule // bps_sender
`default_nettype wire

// File: tb/bps_sink_model.sv
// sink model: takes packet words from the sender's output stream
// assumes: one clock, word taken on a rising edge with valid and ready
`timescale 1ns/1ns
`default_nettype none
module bps_sink_model (
    input wire logic clk,
    input wire logic outValid,
    output logic outReady,
    input wire logic [31:0] outData,
    input wire logic outFirst,
    input wire logic outLast
);
    logic [33:0] got[$];
    logic slow = 1'b0;
    int n = 0;
    initial outReady = 1'b1;
    // slow mode takes one word in three
    always @(negedge clk) begin
        n <= n + 1;
        outReady <= !slow || (n % 3 == 0);
    end
    always @(posedge clk) begin
        if (outValid && outReady) got.push_back({outLast, outFirst, outData});
    end
endmodule // bps_sink_model
`default_nettype wire

// File: tb/bps_sender_tb_top.sv
// testbench top: island, null and metadata packets of the sender
// assumes: package, fifo, sender and sink model compiled before
`timescale 1ns/1ns
`default_nettype none
module bps_sender_tb_top;
    logic clk, reset_n, portEnable, hdmiMode, audioEnable, vblank, hActive, packetSlot;
    logic islandWe, metaConfWe, metaHeaderWe, metaMiscWe, outValid, outReady, outFirst, outLast;
    logic [3:0] islandEnable;
    logic [1:0] islandType, rdType, metaCtlWe, metaDataWe;
    logic [5:0] islandIdx, rdIdx;
    logic [31:0] islandWdata, rdData, metaCtlWdata, metaDataWdata, metaConfWdata, outData;
    logic [31:0] metaHeaderWdata, metaMiscWdata, metaBuf0Control, metaBuf1Control, metaChainConfig;
    int n_fail = 0;
    int checked = 0;
    bps_sender u_bps_sender (.clk, .reset_n, .portEnable, .hdmiMode, .audioEnable, .vblank,
        .hActive, .packetSlot, .islandEnable, .islandWe, .islandType, .islandIdx, .islandWdata,
        .rdType, .rdIdx, .rdData, .metaCtlWe, .metaCtlWdata, .metaDataWe, .metaDataWdata,
        .metaConfWe, .metaConfWdata, .metaHeaderWe, .metaHeaderWdata, .metaMiscWe,
        .metaMiscWdata, .metaBuf0Control, .metaBuf1Control, .metaChainConfig, .outValid,
        .outReady, .outData, .outFirst, .outLast);
    bps_sink_model u_bps_sink_model (.clk, .outValid, .outReady, .outData, .outFirst, .outLast);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] pat(logic [1:0] t, logic [5:0] i);
        return {24'hA5C300, t, i};
    endfunction
    function automatic logic [7:0] ecc(logic [1:0] t);
        logic [31:0] x = 32'h0;
        for (int i = 0; i < 9; i++) x ^= pat(t, 6'(i));
        return x[31:24] ^ x[23:16] ^ x[15:8] ^ x[7:0];
    endfunction
    task automatic cmpWord(logic [33:0] g, logic [33:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmpReg(logic [31:0] g, logic [31:0] e);
        cmpWord({2'h0, g}, {2'h0, e});
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic slot();
        packetSlot = 1'b1;
        tick(1);
        packetSlot = 1'b0;
    endtask
    // waits for n words, then checks that no more follow
    task automatic expectN(int n);
        for (int k = 0; k < 300 && u_bps_sink_model.got.size() < n; k++) tick(1);
        tick(12);
        cmpReg(32'(u_bps_sink_model.got.size()), 32'(n));
    endtask
    task automatic chkPkt(int b, logic [1:0] t, logic nul);
        for (int i = 0; i < 9; i++)
            cmpWord(u_bps_sink_model.got[b+i], {i == 8, i == 0, nul ? 32'h0 : pat(t, 6'(i))});
    endtask
    task automatic fillIsl(logic [1:0] t, int n);
        islandType = t;
        islandWe = 1'b1;
        for (int i = 0; i < n; i++) begin
            islandIdx = 6'(i);
            islandWdata = pat(t, 6'(i));
            tick(1);
        end
        islandWe = 1'b0;
        tick(1);
    endtask
    task automatic ctl(logic [31:0] d);
        metaCtlWdata = d;
        metaCtlWe = 2'h3;
        tick(1);
        metaCtlWe = 2'h0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testReset();
        cmpReg(metaBuf0Control, 32'h0100_0000);
        cmpReg(metaBuf1Control, 32'h0100_0000);
        cmpReg(metaChainConfig, 32'h0);
        $display("test reset done");
    endtask
    task automatic testIsland();
        fillIsl(2'h0, 9);
        fillIsl(2'h1, 9);
        islandEnable = 4'h1;
        tick(1);
        slot();
        expectN(9);
        chkPkt(0, 2'h0, 1'b0);
        islandEnable = 4'h3;
        slot();
        expectN(18);
        chkPkt(9, 2'h0, 1'b0);
        slot();
        rdType = 2'h1;
        rdIdx = 6'h05;
        tick(2);
        cmpReg(rdData, pat(2'h1, 6'h05));
        rdIdx = 6'h21;
        tick(2);
        cmpReg({24'h0, rdData[7:0]}, {24'h0, ecc(2'h1)});
        expectN(36);
        chkPkt(18, 2'h0, 1'b0);
        chkPkt(27, 2'h1, 1'b0);
        $display("test island done");
    endtask
    task automatic testEnableDrop();
        u_bps_sink_model.got.delete();
        islandEnable = 4'h1;
        u_bps_sink_model.slow = 1'b1;
        tick(1);
        slot();
        tick(8);
        islandEnable = 4'h0;
        expectN(9);
        chkPkt(0, 2'h0, 1'b0);
        u_bps_sink_model.slow = 1'b0;
        $display("test enable drop done");
    endtask
    task automatic testNull();
        u_bps_sink_model.got.delete();
        hdmiMode = 1'b1;
        tick(1);
        slot();
        expectN(9);
        chkPkt(0, 2'h0, 1'b1);
        hdmiMode = 1'b0;
        $display("test null done");
    endtask
    task automatic testPortOff();
        u_bps_sink_model.got.delete();
        islandEnable = 4'h1;
        tick(1);
        slot();
        tick(4);
        portEnable = 1'b0;
        expectN(2);
        cmpWord(u_bps_sink_model.got[1], {2'h0, pat(2'h0, 6'h01)});
        portEnable = 1'b1;
        $display("test port off done");
    endtask
    task automatic testPps();
        u_bps_sink_model.got.delete();
        fillIsl(2'h3, 33);
        islandEnable = 4'h9;
        tick(1);
        slot();
        expectN(42);
        chkPkt(0, 2'h0, 1'b0);
        for (int i = 0; i < 33; i++)
            cmpWord(u_bps_sink_model.got[9+i], {i == 32, i == 0, pat(2'h3, 6'(i))});
        islandEnable = 4'h0;
        $display("test pps done");
    endtask
    task automatic testMeta();
        u_bps_sink_model.got.delete();
        metaConfWdata = 32'h1;
        metaHeaderWdata = pat(2'h2, 6'h00);
        {metaConfWe, metaHeaderWe} = 2'h3;
        tick(1);
        {metaConfWe, metaHeaderWe} = 2'h0;
        ctl(32'h0000_4000);
        metaDataWe = 2'h3;
        for (int i = 1; i < 9; i++) begin
            metaDataWdata = pat(2'h2, 6'(i));
            tick(1);
        end
        metaDataWe = 2'h0;
        cmpReg(metaBuf0Control, 32'h0000_4008);
        ctl(32'h0001_4008);
        cmpReg(metaBuf0Control, 32'h0001_4008);
        {audioEnable, vblank} = 2'h3;
        tick(20);
        cmpReg(32'(u_bps_sink_model.got.size()), 32'h0);
        hActive = 1'b1;
        expectN(18);
        chkPkt(0, 2'h2, 1'b0);
        chkPkt(9, 2'h2, 1'b0);
        cmpReg({30'h0, metaBuf0Control[24], metaBuf0Control[16]}, 32'h2);
        cmpReg({30'h0, metaBuf1Control[24], metaBuf1Control[16]}, 32'h2);
        cmpReg(metaChainConfig, 32'h8000_0001);
        {audioEnable, vblank, hActive} = 3'h0;
        ctl(32'h0000_40FF);
        metaDataWe = 2'h1;
        tick(1);
        metaDataWe = 2'h0;
        cmpReg(metaBuf0Control, 32'h0000_4000);
        $display("test meta done");
    endtask
    // ------------------------------------------------------------
    // run and verdict
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {reset_n, hdmiMode, audioEnable, vblank, hActive, packetSlot, islandWe} = '0;
        {metaConfWe, metaHeaderWe, metaMiscWe, metaCtlWe, metaDataWe} = '0;
        {islandEnable, islandType, rdType, islandIdx, rdIdx, islandWdata} = '0;
        {metaCtlWdata, metaDataWdata, metaConfWdata, metaHeaderWdata, metaMiscWdata} = '0;
        portEnable = 1'b1;
        tick(4);
        reset_n = 1'b1;
        testReset();
        testIsland();
        testEnableDrop();
        testNull();
        testPortOff();
        testPps();
        testMeta();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("ERROR t=%0t watchdog expired", $time);
        give_verdict();
    end
endmodule // bps_sender_tb_top
`default_nettype wire
